/* include/math_stats_pkg.sv */
// Purpose: Constants and carrier types for the reading math and statistics unit
// Assumes: 32-bit classic Wishbone, word-aligned registers, signed integer readings
// Notes:   Readings and levels are plain signed integers in the device's own units
//
// What this block does
// - Math enable is one bit, readable as 0 or 1, off after reset.
// - A measurement function change forces math enable off.
// - Math on, or function select while on, clears null, averaging, reference level.
// - Those same events leave the reference resistance untouched.
// - Factory reset, preset and function change return math enable to off.
// - Mean query returns sum over count, zero when no readings.
// - Count query returns readings since averaging enabled, zero when none.
// - Peak high query returns the largest reading, zero when none.
// - Peak low query returns the smallest reading, zero when none.
// - Latest reading query returns the newest reading, zero when none.
// - Statistics clear on averaging enable, select while on, power-on, reset, preset, function change.
// - Relative level reference spans -120 to +120 dBm, defaults to 0 dBm.
// - Level reference returns to default on reset, preset, math or function change.
// - One reference resistance, 1 to 9999 ohms, default 600, serves both decibel modes.
// - Resistance keeps whole ohms only; fractions are truncated, not rounded.
// - Resistance survives power cycle, reset, preset and function changes.
// - Relative decibel result minus stored reference; first computed reading is zero. No reading is captured here; reference stays 0 dBm until a bus write.

package math_stats_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_COMMAND   = 8'h08;
    localparam logic [7:0] ADDR_REF_LEVEL = 8'h0c;
    localparam logic [7:0] ADDR_REF_RES   = 8'h10;
    localparam logic [7:0] ADDR_MEAN      = 8'h14;
    localparam logic [7:0] ADDR_COUNT     = 8'h18;
    localparam logic [7:0] ADDR_PEAK_HIGH = 8'h1c;
    localparam logic [7:0] ADDR_PEAK_LOW  = 8'h20;
    localparam logic [7:0] ADDR_LATEST    = 8'h24;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int CMD_FUNC_LSB     = 0;
    localparam int CMD_SELECT_BIT   = 4;
    localparam int CMD_MEAS_BIT     = 5;
    localparam int CMD_RESET_BIT    = 6;
    localparam int CMD_PRESET_BIT   = 7;
    localparam int RES_FRAC_BITS    = 8;
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_RES_BAD_BIT = 1;
    localparam int STAT_LVL_BAD_BIT = 2;

    // ----------------------------------------------------------------
    // Reset values and limits
    // ----------------------------------------------------------------
    localparam logic [13:0] RES_DEFAULT  = 14'h0258;
    localparam logic [13:0] RES_MIN      = 14'h0001;
    localparam logic [13:0] RES_MAX      = 14'h270f;
    localparam logic [31:0] LEVEL_LIMIT  = 32'h0000_0078;
    localparam logic [31:0] LEVEL_RESET  = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

    typedef enum logic [2:0] {
        FN_AVERAGE, FN_DB, FN_DBM, FN_HOLD, FN_LIMIT, FN_NULL
    } math_fn_t;

    typedef enum logic [1:0] {
        DIV_IDLE, DIV_RUN, DIV_DONE
    } div_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] value;
    } reading_t;

endpackage

/* rtl/math_stats_unit.sv */
// Purpose: Math enable, running statistics and decibel references
// Assumes: Readings arrive as one-cycle valid strobes; nonvolatile copy lives outside
// Notes:   Mean uses a serial divider so queries stall until the quotient is ready
`timescale 1ns/1ns

module math_stats_unit #(
    parameter int CNT_W = 32,
    parameter int SUM_W = 64
) (
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire math_stats_pkg::wb_req_t  wb_req,
    output      math_stats_pkg::wb_rsp_t  wb_rsp,
    input  wire math_stats_pkg::reading_t reading,
    input  wire logic [13:0]              nv_res_value,
    input  wire logic                     nv_res_valid,
    output      logic [13:0]              nv_res_store,
    output      logic                     nv_res_write,
    output      logic                     math_enable,
    output      logic [2:0]               math_function,
    output      logic [31:0]              level_reference,
    output      logic [13:0]              ref_resistance,
    output      logic                     null_clear
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                       enable;
        math_stats_pkg::math_fn_t   func;
        logic [31:0]                level;
        logic [13:0]                res;
        logic                       res_loaded;
        logic [SUM_W-1:0]           sum;
        logic [CNT_W-1:0]           count;
        logic signed [31:0]         peak_high;
        logic signed [31:0]         peak_low;
        logic signed [31:0]         latest;
        logic                       res_bad;
        logic                       lvl_bad;
        logic                       null_clr;
        logic                       nv_wr;
        math_stats_pkg::div_state_t div_st;
        logic [SUM_W-1:0]           div_rem;
        logic [SUM_W-1:0]           div_quo;
        logic                       div_neg;
        logic [6:0]                 div_cnt;
        math_stats_pkg::wb_rsp_t    rsp;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Release is synchronised, assertion stays asynchronous
    logic [1:0] rst_sync_q;
    logic       rst_n;
    assign rst_n = rst_sync_q[1];

    function automatic logic is_access(input math_stats_pkg::wb_req_t r, input logic [7:0] a);
        return r.cyc && r.stb && (r.adr == a);
    endfunction

    function automatic logic signed [31:0] res_truncate(input logic [31:0] fixed_ohms);
        return $signed(32'(fixed_ohms >> math_stats_pkg::RES_FRAC_BITS));
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic                   new_req;
    logic                   wr;
    logic                   clear_stats;
    logic                   clear_math;
    logic                   force_off;
    logic signed [31:0]     rv;
    logic signed [31:0]     res_in;
    logic signed [31:0]     lvl_in;
    logic [SUM_W-1:0]       sum_abs;
    logic [SUM_W:0]         trial;

    always_comb begin
        s_d         = s_q;
        s_d.null_clr = 1'b0;
        s_d.nv_wr   = 1'b0;
        new_req     = wb_req.cyc && wb_req.stb && !s_q.rsp.ack && !s_q.rsp.err;
        wr          = new_req && wb_req.we;
        clear_stats = 1'b0;
        clear_math  = 1'b0;
        force_off   = 1'b0;
        rv          = $signed(reading.value);
        res_in      = res_truncate(wb_req.dat);
        lvl_in      = $signed(wb_req.dat);
        sum_abs     = s_q.sum[SUM_W-1] ? SUM_W'(-s_q.sum) : s_q.sum;
        trial       = '0;
        s_d.rsp.ack = 1'b0;
        s_d.rsp.err = 1'b0;

        // Resistance comes back from nonvolatile storage once after every reset release
        if (nv_res_valid && !s_q.res_loaded) begin
            s_d.res        = nv_res_value;
            s_d.res_loaded = 1'b1;
        end

        if (reading.valid && s_q.enable && s_q.func == math_stats_pkg::FN_AVERAGE) begin
            s_d.sum       = s_q.sum + SUM_W'(rv);
            s_d.count     = s_q.count + CNT_W'(1);
            s_d.latest    = rv;
            s_d.peak_high = (s_q.count == '0 || rv > s_q.peak_high) ? rv : s_q.peak_high;
            s_d.peak_low  = (s_q.count == '0 || rv < s_q.peak_low) ? rv : s_q.peak_low;
        end

        if (wr && is_access(wb_req, math_stats_pkg::ADDR_CONTROL) && wb_req.sel[0]) begin
            if (wb_req.dat[math_stats_pkg::CTRL_ENABLE_BIT] && !s_q.enable) begin
                clear_math  = 1'b1;
                clear_stats = 1'b1;
            end
            s_d.enable = wb_req.dat[math_stats_pkg::CTRL_ENABLE_BIT];
        end

        if (wr && is_access(wb_req, math_stats_pkg::ADDR_COMMAND) && wb_req.sel[0]) begin
            if (wb_req.dat[math_stats_pkg::CMD_SELECT_BIT]) begin
                s_d.func = math_stats_pkg::math_fn_t'(wb_req.dat[math_stats_pkg::CMD_FUNC_LSB +: 3]);
                s_d.level = math_stats_pkg::LEVEL_RESET;
                if (s_q.enable) begin
                    clear_math  = 1'b1;
                    clear_stats = 1'b1;
                end
            end
            if (wb_req.dat[math_stats_pkg::CMD_MEAS_BIT] || wb_req.dat[math_stats_pkg::CMD_RESET_BIT]
                || wb_req.dat[math_stats_pkg::CMD_PRESET_BIT]) begin
                force_off = 1'b1;
            end
            if (wb_req.dat[math_stats_pkg::CMD_RESET_BIT] || wb_req.dat[math_stats_pkg::CMD_PRESET_BIT]) begin
                s_d.func = math_stats_pkg::FN_NULL;
            end
        end

        if (force_off) begin
            s_d.enable  = 1'b0;
            clear_math  = 1'b1;
            clear_stats = 1'b1;
        end

        // Resistance is never touched here, so it survives every clear
        if (clear_math) begin
            s_d.level    = math_stats_pkg::LEVEL_RESET;
            s_d.null_clr = 1'b1;
        end
        if (clear_stats) begin
            s_d.sum       = '0;
            s_d.count     = '0;
            s_d.peak_high = '0;
            s_d.peak_low  = '0;
            s_d.latest    = '0;
        end

        if (wr && is_access(wb_req, math_stats_pkg::ADDR_REF_LEVEL)) begin
            // Writes outside the decibel function or with math off are refused, range too
            if (s_q.enable && s_q.func == math_stats_pkg::FN_DB && lvl_in <= $signed(math_stats_pkg::LEVEL_LIMIT)
                && lvl_in >= -$signed(math_stats_pkg::LEVEL_LIMIT)) begin
                s_d.level   = wb_req.dat;
                s_d.lvl_bad = 1'b0;
            end else begin
                s_d.lvl_bad = 1'b1;
            end
        end

        if (wr && is_access(wb_req, math_stats_pkg::ADDR_REF_RES)) begin
            if (res_in >= $signed(32'(math_stats_pkg::RES_MIN)) && res_in <= $signed(32'(math_stats_pkg::RES_MAX))) begin
                s_d.res     = res_in[13:0];
                s_d.nv_wr   = 1'b1;
                s_d.res_bad = 1'b0;
            end else begin
                s_d.res_bad = 1'b1;
            end
        end

        // Serial restoring divider: one quotient bit per cycle, no wide divider
        unique case (s_q.div_st)
            math_stats_pkg::DIV_IDLE: begin
                if (new_req && !wb_req.we && is_access(wb_req, math_stats_pkg::ADDR_MEAN)) begin
                    s_d.div_quo = sum_abs;
                    s_d.div_rem = '0;
                    s_d.div_neg = s_q.sum[SUM_W-1];
                    s_d.div_cnt = 7'(SUM_W);
                    s_d.div_st  = (s_q.count == '0) ? math_stats_pkg::DIV_DONE : math_stats_pkg::DIV_RUN;
                    if (s_q.count == '0) begin
                        s_d.div_quo = '0;
                    end
                end
            end
            math_stats_pkg::DIV_RUN: begin
                trial = {s_q.div_rem, s_q.div_quo[SUM_W-1]} - (SUM_W+1)'(s_q.count);
                if (!trial[SUM_W]) begin
                    s_d.div_rem = trial[SUM_W-1:0];
                    s_d.div_quo = {s_q.div_quo[SUM_W-2:0], 1'b1};
                end else begin
                    s_d.div_rem = {s_q.div_rem[SUM_W-2:0], s_q.div_quo[SUM_W-1]};
                    s_d.div_quo = {s_q.div_quo[SUM_W-2:0], 1'b0};
                end
                s_d.div_cnt = s_q.div_cnt - 7'd1;
                if (s_q.div_cnt == 7'd1) begin
                    s_d.div_st = math_stats_pkg::DIV_DONE;
                end
            end
            math_stats_pkg::DIV_DONE: begin
                s_d.div_st = math_stats_pkg::DIV_IDLE;
            end
            default: s_d.div_st = math_stats_pkg::DIV_IDLE;
        endcase

        // Bus answer; mean answers from DIV_DONE, all else next cycle
        if (new_req) begin
            s_d.rsp.dat = math_stats_pkg::ZERO_WORD;
            unique case (wb_req.adr)
                math_stats_pkg::ADDR_CONTROL:   s_d.rsp.dat = 32'(s_q.enable);
                math_stats_pkg::ADDR_STATUS:    s_d.rsp.dat = {29'h0, s_q.lvl_bad, s_q.res_bad,
                                                               s_q.div_st != math_stats_pkg::DIV_IDLE};
                math_stats_pkg::ADDR_COMMAND:   s_d.rsp.dat = 32'(s_q.func);
                math_stats_pkg::ADDR_REF_LEVEL: s_d.rsp.dat = s_q.level;
                math_stats_pkg::ADDR_REF_RES:   s_d.rsp.dat = 32'(s_q.res) << math_stats_pkg::RES_FRAC_BITS;
                math_stats_pkg::ADDR_COUNT:     s_d.rsp.dat = 32'(s_q.count);
                math_stats_pkg::ADDR_PEAK_HIGH: s_d.rsp.dat = s_q.peak_high;
                math_stats_pkg::ADDR_PEAK_LOW:  s_d.rsp.dat = s_q.peak_low;
                math_stats_pkg::ADDR_LATEST:    s_d.rsp.dat = s_q.latest;
                default:                        s_d.rsp.dat = math_stats_pkg::ZERO_WORD;
            endcase
            if (wb_req.adr == math_stats_pkg::ADDR_MEAN) begin
                s_d.rsp.ack = s_q.div_st == math_stats_pkg::DIV_DONE && !wb_req.we;
                s_d.rsp.err = wb_req.we;
                s_d.rsp.dat = s_q.div_neg ? 32'(-s_q.div_quo) : 32'(s_q.div_quo);
            end else if (wb_req.adr > math_stats_pkg::ADDR_LATEST || wb_req.adr[1:0] != 2'b00) begin
                s_d.rsp.err = 1'b1;
            end else begin
                s_d.rsp.ack = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.enable     <= 1'b0;
            s_q.func       <= math_stats_pkg::FN_NULL;
            s_q.level      <= math_stats_pkg::LEVEL_RESET;
            s_q.res        <= math_stats_pkg::RES_DEFAULT;
            s_q.res_loaded <= 1'b0;
            s_q.sum        <= '0;
            s_q.count      <= '0;
            s_q.peak_high  <= '0;
            s_q.peak_low   <= '0;
            s_q.latest     <= '0;
            s_q.res_bad    <= 1'b0;
            s_q.lvl_bad    <= 1'b0;
            s_q.null_clr   <= 1'b0;
            s_q.nv_wr      <= 1'b0;
            s_q.div_st     <= math_stats_pkg::DIV_IDLE;
            s_q.div_rem    <= '0;
            s_q.div_quo    <= '0;
            s_q.div_neg    <= 1'b0;
            s_q.div_cnt    <= '0;
            s_q.rsp        <= '0;
        end else begin
            s_q.enable     <= s_d.enable;
            s_q.func       <= s_d.func;
            s_q.level      <= s_d.level;
            s_q.res        <= s_d.res;
            s_q.res_loaded <= s_d.res_loaded;
            s_q.sum        <= s_d.sum;
            s_q.count      <= s_d.count;
            s_q.peak_high  <= s_d.peak_high;
            s_q.peak_low   <= s_d.peak_low;
            s_q.latest     <= s_d.latest;
            s_q.res_bad    <= s_d.res_bad;
            s_q.lvl_bad    <= s_d.lvl_bad;
            s_q.null_clr   <= s_d.null_clr;
            s_q.nv_wr      <= s_d.nv_wr;
            s_q.div_st     <= s_d.div_st;
            s_q.div_rem    <= s_d.div_rem;
            s_q.div_quo    <= s_d.div_quo;
            s_q.div_neg    <= s_d.div_neg;
            s_q.div_cnt    <= s_d.div_cnt;
            s_q.rsp        <= s_d.rsp;
        end
    end

    assign wb_rsp          = s_q.rsp;
    assign math_enable     = s_q.enable;
    assign math_function   = s_q.func;
    // Decibel arithmetic sits downstream and reads these two
    assign level_reference = s_q.level;
    assign ref_resistance  = s_q.res;
    assign nv_res_store    = s_q.res;
    assign nv_res_write    = s_q.nv_wr;
    assign null_clear      = s_q.null_clr;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence cmd_write(int bitpos);
        wr && is_access(wb_req, math_stats_pkg::ADDR_COMMAND) && wb_req.sel[0] && wb_req.dat[bitpos];
    endsequence

    chk_enable_reset_off: assert property (@(posedge clk) $rose(rst_n) |-> !math_enable)
        else $error("math enable not off after reset");
    chk_meas_forces_off: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_write(math_stats_pkg::CMD_MEAS_BIT) |=> !math_enable)
        else $error("enable survived function change");
    chk_preset_forces_off: assert property (@(posedge clk) disable iff (!rst_n)
        cmd_write(math_stats_pkg::CMD_PRESET_BIT) |=> !math_enable && s_q.count == '0)
        else $error("preset did not clear");
    chk_enable_clears_stats: assert property (@(posedge clk) disable iff (!rst_n)
        (clear_stats && !reading.valid) |=> s_q.count == '0 && s_q.latest == '0)
        else $error("statistics not cleared");
    chk_clear_keeps_res: assert property (@(posedge clk) disable iff (!rst_n)
        (clear_math && s_q.res_loaded) |=> $stable(ref_resistance))
        else $error("resistance changed by math clear");
    chk_res_in_range: assert property (@(posedge clk) disable iff (!rst_n)
        ref_resistance >= math_stats_pkg::RES_MIN && ref_resistance <= math_stats_pkg::RES_MAX)
        else $error("resistance out of range");
    chk_level_in_range: assert property (@(posedge clk) disable iff (!rst_n)
        $signed(level_reference) <= $signed(math_stats_pkg::LEVEL_LIMIT)
        && $signed(level_reference) >= -$signed(math_stats_pkg::LEVEL_LIMIT))
        else $error("level reference out of range");
    chk_peak_order: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.count != '0 |-> s_q.peak_low <= s_q.latest && s_q.latest <= s_q.peak_high)
        else $error("extremes do not bracket latest reading");
    chk_mean_answer: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.div_st == math_stats_pkg::DIV_DONE && new_req && !wb_req.we
         && wb_req.adr == math_stats_pkg::ADDR_MEAN) |=> wb_rsp.ack)
        else $error("mean not answered after divide");

endmodule // math_stats_unit

/* verif/reading_source_model.sv */
// Purpose: Far side: reading source and nonvolatile resistance store
// Assumes: Store keeps its word across resets of the unit
// Notes:   Valid stays high so every restart can restore
`timescale 1ns/1ns

module reading_source_model (
    input  wire logic                     clk,
    output      math_stats_pkg::reading_t reading,
    output      logic [13:0]              nv_res_value,
    output      logic                     nv_res_valid,
    input  wire logic [13:0]              nv_res_store,
    input  wire logic                     nv_res_write
);
    logic [13:0] nv_q = math_stats_pkg::RES_DEFAULT;

    always @(posedge clk) begin
        if (nv_res_write) begin
            nv_q <= nv_res_store;
        end
    end
    assign nv_res_value = nv_q;
    assign nv_res_valid = 1'b1;
    initial reading = '0;

    // Stale value inverted so a late sample cannot pass by luck
    task automatic send(input logic [31:0] v);
        @(posedge clk);
        reading <= '{valid: 1'b1, value: v};
        @(posedge clk);
        reading <= '{valid: 1'b0, value: ~v};
    endtask
endmodule // reading_source_model

/* verif/math_stats_unit_test.sv */
// Purpose: Self-checking bench for the math and statistics unit
// Assumes: Partner model supplies readings and the resistance copy
// Notes:   Mean reads stall up to 66 cycles, so waits allow 200
`timescale 1ns/1ns

module math_stats_unit_test;
    logic                     clk;
    logic                     resetn;
    math_stats_pkg::wb_req_t  wb_req;
    math_stats_pkg::wb_rsp_t  wb_rsp;
    math_stats_pkg::reading_t reading;
    logic [13:0]              nv_res_value;
    logic                     nv_res_valid;
    logic [13:0]              nv_res_store;
    logic                     nv_res_write;
    logic                     math_enable;
    logic [2:0]               math_function;
    logic [31:0]              level_reference;
    logic [13:0]              ref_resistance;
    logic                     null_clear;
    logic [31:0]              rd;
    logic                     er;
    int                       n_mismatch = 0;
    int                       samples_checked = 0;

    math_stats_unit u_math_stats_unit (.clk(clk), .resetn(resetn), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .reading(reading), .nv_res_value(nv_res_value), .nv_res_valid(nv_res_valid),
        .nv_res_store(nv_res_store), .nv_res_write(nv_res_write), .math_enable(math_enable),
        .math_function(math_function), .level_reference(level_reference),
        .ref_resistance(ref_resistance), .null_clear(null_clear));
    reading_source_model u_reading_source_model (.clk(clk), .reading(reading), .nv_res_value(nv_res_value),
        .nv_res_valid(nv_res_valid), .nv_res_store(nv_res_store), .nv_res_write(nv_res_write));

    // ----------------------------------------------------------------
    // Bus and compare helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until the rising edge that samples ack or err high
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_rsp.ack !== 1'b1 && wb_rsp.err !== 1'b1 && n < 200);
        if (n >= 200) n_mismatch++;
        rd = wb_rsp.dat;
        er = wb_rsp.err;
        wb_req <= '0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk({31'h0, er}, 32'h0);
        chk(rd, e);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_defaults;
        chk({31'h0, math_enable}, 32'h0);
        chk({18'h0, ref_resistance}, 32'h258);
        rdchk(8'h00, 32'h0);
        rdchk(8'h14, 32'h0);
        rdchk(8'h18, 32'h0);
        rdchk(8'h1c, 32'h0);
        rdchk(8'h20, 32'h0);
        rdchk(8'h24, 32'h0);
        rdchk(8'h0c, 32'h0);
    endtask

    task automatic t_stats;
        bus(1'b1, 8'h08, 32'h10);
        bus(1'b1, 8'h00, 32'h1);
        chk({31'h0, null_clear}, 32'h1);
        rdchk(8'h00, 32'h1);
        u_reading_source_model.send(32'h5);
        u_reading_source_model.send(32'hffff_fffd);
        u_reading_source_model.send(32'ha);
        rdchk(8'h18, 32'h3);
        rdchk(8'h14, 32'h4);
        rdchk(8'h1c, 32'ha);
        rdchk(8'h20, 32'hffff_fffd);
        rdchk(8'h24, 32'ha);
        bus(1'b1, 8'h08, 32'h10);
        rdchk(8'h18, 32'h0);
        u_reading_source_model.send(32'h7);
        rdchk(8'h24, 32'h7);
        bus(1'b1, 8'h08, 32'h20);
        chk({31'h0, math_enable}, 32'h0);
        rdchk(8'h18, 32'h0);
        rdchk(8'h24, 32'h0);
    endtask

    task automatic t_level;
        bus(1'b1, 8'h08, 32'h11);
        chk({29'h0, math_function}, 32'h1);
        bus(1'b1, 8'h00, 32'h1);
        bus(1'b1, 8'h0c, 32'hffff_ff88);
        rdchk(8'h0c, 32'hffff_ff88);
        bus(1'b1, 8'h0c, 32'h79);
        rdchk(8'h0c, 32'hffff_ff88);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd & 32'h4, 32'h4);
        bus(1'b1, 8'h0c, 32'h78);
        chk(level_reference, 32'h78);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h00, 32'h1);
        rdchk(8'h0c, 32'h0);
        bus(1'b1, 8'h0c, 32'hffff_fff6);
        bus(1'b1, 8'h08, 32'h80);
        chk({31'h0, math_enable}, 32'h0);
        chk(level_reference, 32'h0);
    endtask

    task automatic t_res;
        bus(1'b1, 8'h10, 32'h0001_2cb3);
        rdchk(8'h10, 32'h0001_2c00);
        bus(1'b1, 8'h10, 32'h80);
        chk({18'h0, ref_resistance}, 32'h12c);
        bus(1'b1, 8'h08, 32'h11);
        bus(1'b1, 8'h00, 32'h1);
        bus(1'b1, 8'h08, 32'h11);
        chk({18'h0, ref_resistance}, 32'h12c);
        bus(1'b1, 8'h08, 32'h40);
        chk({18'h0, ref_resistance}, 32'h12c);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        chk({18'h0, ref_resistance}, 32'h12c);
        bus(1'b1, 8'h10, 32'h0027_0f00);
        bus(1'b1, 8'h10, 32'h0027_1000);
        chk({18'h0, ref_resistance}, 32'h270f);
        bus(1'b1, 8'h28, 32'h0);
        chk({31'h0, er}, 32'h1);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        resetn = 1'b0;
        wb_req = '0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        t_defaults;
        t_stats;
        t_level;
        t_res;
        final_report;
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        final_report;
    end
endmodule // math_stats_unit_test
